// [rtl/bridge_tuning_control_upper.sv]
// What this block does
// - Bit 15 picks credit update pacing
// - Bit 16 sticky retry expiry, writing one clears
// - Bits 18:17 select retry expiry limit
// - Bit 19 or bridge bit 27 disables discard timer
// - Bit 20 forces 64-clock discard time
// - Otherwise bridge bit 24/25 picks time
// - Bits 22:21 pick config retry timeout
// - Bit 23 forces in-order delayed transactions
// - Bits 25:24 pick completion timeout
// - Bit 26 maps upstream memory to programmed class
// - Bits 29:27 programmable class, reset one
// - Bit 30 loopback only with strap pattern
// - Bit 30 writable only in reverse mode
// - Bit 31 locks out primary config access
`timescale 1ns/1ps
`default_nettype none
module bridge_tuning_control_upper
  import tuning_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire tuning_pkg::cfg_req_s cfg_req,
  output tuning_pkg::cfg_rsp_s     cfg_rsp,
  input  wire logic [31:0]         bridge_ctrl,
  input  wire logic                test_strap_zero,
  input  wire logic                test_strap_one,
  input  wire logic                test_strap_two,
  input  wire logic                mask_input_strap,
  input  wire logic                direction_select_strap,
  input  wire logic                retry_seen,
  input  wire logic                txn_start,
  output logic                     retry_expired,
  output logic                     fc_update_each_credit,
  output logic                     discard_timer_enable,
  output logic [15:0]              discard_clocks,
  output logic [31:0]              cfg_retry_cycles,
  output logic [31:0]              cpl_timeout_cycles,
  output logic                     dt_in_order,
  output logic [2:0]               upstream_tc,
  output logic                     loopback_active,
  output logic                     primary_lockout
);
  import tuning_pkg::*;

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  logic [4:0] strap_raw;
  logic [4:0] strap;
  assign strap_raw = {direction_select_strap, mask_input_strap, test_strap_two,
                      test_strap_one, test_strap_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      sync_two_ff i_sync_two_ff (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (strap_raw[gi]),
        .dout    (strap[gi])
      );
    end
  endgenerate

  logic reverse_mode;
  assign reverse_mode = strap[4];

  // ----------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------
  logic       fc_pace;
  logic       retry_flag;
  logic [1:0] retry_lim;
  logic       discard_dis;
  logic       discard_short;
  logic [1:0] cfg_retry_sel;
  logic       dt_order;
  logic [1:0] cpl_to_sel;
  logic       iso_en;
  logic [2:0] iso_tc;
  logic       loopback;
  logic       lockout;
  logic       strap_loaded;
  logic       retry_hit;

  logic cfg_hit;
  logic pri_blocked;
  logic wr_hit;
  logic rd_hit;
  assign cfg_hit     = cfg_req.valid && cfg_req.addr == TUNING_OFFSET;
  assign pri_blocked = lockout && cfg_req.from_primary;
  // A refused primary write leaves every field untouched
  assign wr_hit      = cfg_hit && cfg_req.write && !pri_blocked;
  assign rd_hit      = cfg_hit && !cfg_req.write;

  // Bits 14:0 live in another block; zero here so reads can be merged
  logic [31:0] reg_value;
  always_comb begin
    reg_value                      = 32'h0000_0000;
    reg_value[FC_PACE_BIT]         = fc_pace;
    reg_value[RETRY_FLAG_BIT]      = retry_flag;
    reg_value[RETRY_LIM_LO +: 2]   = retry_lim;
    reg_value[DISCARD_DIS_BIT]     = discard_dis;
    reg_value[DISCARD_SHORT_BIT]   = discard_short;
    reg_value[CFG_RETRY_LO +: 2]   = cfg_retry_sel;
    reg_value[DT_ORDER_BIT]        = dt_order;
    reg_value[CPL_TO_LO +: 2]      = cpl_to_sel;
    reg_value[ISO_EN_BIT]          = iso_en;
    reg_value[ISO_TC_LO +: 3]      = iso_tc;
    reg_value[LOOPBACK_BIT]        = loopback;
    reg_value[LOCKOUT_BIT]         = lockout;
  end

  // ----------------------------------------------------------------
  // Plain read/write fields, byte lanes 1 to 3
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fc_pace       <= 1'b0;
      retry_lim     <= RETRY_LIM_RST;
      discard_dis   <= 1'b0;
      discard_short <= 1'b0;
      cfg_retry_sel <= CFG_RETRY_RST;
      dt_order      <= 1'b0;
      cpl_to_sel    <= CPL_TO_RST;
      iso_en        <= 1'b0;
      iso_tc        <= ISO_TC_RST;
    end else if (wr_hit) begin
      if (cfg_req.be[1]) fc_pace <= cfg_req.wdata[FC_PACE_BIT];
      if (cfg_req.be[2]) begin
        retry_lim     <= cfg_req.wdata[RETRY_LIM_LO +: 2];
        discard_dis   <= cfg_req.wdata[DISCARD_DIS_BIT];
        discard_short <= cfg_req.wdata[DISCARD_SHORT_BIT];
        cfg_retry_sel <= cfg_req.wdata[CFG_RETRY_LO +: 2];
        dt_order      <= cfg_req.wdata[DT_ORDER_BIT];
      end
      if (cfg_req.be[3]) begin
        cpl_to_sel <= cfg_req.wdata[CPL_TO_LO +: 2];
        iso_en     <= cfg_req.wdata[ISO_EN_BIT];
        iso_tc     <= cfg_req.wdata[ISO_TC_LO +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Loopback: reverse mode only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      loopback <= 1'b0;
    end else if (wr_hit && cfg_req.be[3] && reverse_mode) begin
      loopback <= cfg_req.wdata[LOOPBACK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Lockout, loaded from strap once synchronisers settle
  // ----------------------------------------------------------------
  // The lockout strap is taken once; later strap moves leave lockout alone
  logic [1:0] settle;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      settle       <= 2'h0;
      strap_loaded <= 1'b0;
      lockout      <= 1'b0;
    end else if (!strap_loaded) begin
      settle <= settle + 2'h1;
      if (settle == 2'h2) begin
        strap_loaded <= 1'b1;
        lockout      <= strap[0];
      end
    end else if (wr_hit && cfg_req.be[3]) begin
      lockout <= cfg_req.wdata[LOCKOUT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Retry counting and one-cycle expiry pulse
  // ----------------------------------------------------------------
  logic [31:0] retry_count;
  logic [31:0] retry_limit_val;
  always_comb begin
    unique case (retry_lim)
      2'h0: retry_limit_val = 32'h0000_0000;
      2'h1: retry_limit_val = RETRY_LIM1;
      2'h2: retry_limit_val = RETRY_LIM2;
      2'h3: retry_limit_val = RETRY_LIM3;
    endcase
  end

  // Limit 00 never matches, so the count only saturates
  logic [31:0] next_retry_count;
  assign next_retry_count = retry_count + 32'h1;
  assign retry_hit = retry_seen && !txn_start && retry_lim != 2'h0
                     && next_retry_count >= retry_limit_val;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      retry_count <= 32'h0;
    end else if (txn_start) begin
      retry_count <= 32'h0;
    end else if (retry_hit) begin
      retry_count <= 32'h0;
    end else if (retry_seen && retry_count != 32'hFFFF_FFFF) begin
      retry_count <= next_retry_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      retry_expired <= 1'b0;
    end else begin
      retry_expired <= retry_hit;
    end
  end

  // ----------------------------------------------------------------
  // Sticky expiry flag
  // ----------------------------------------------------------------
  logic flag_clear;
  assign flag_clear = wr_hit && cfg_req.be[2] && cfg_req.wdata[RETRY_FLAG_BIT];

  // Set wins over a same-cycle clear so no expiry is lost
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      retry_flag <= 1'b0;
    end else if (retry_hit) begin
      retry_flag <= 1'b1;
    end else if (flag_clear) begin
      retry_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Config response, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.valid           <= cfg_hit;
      cfg_rsp.lockout_refused <= cfg_hit && pri_blocked;
      cfg_rsp.rdata           <= (rd_hit && !pri_blocked) ? reg_value : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [31:0] cfg_cycles;
  logic [31:0] cpl_cycles;
  always_comb begin
    unique case (cfg_retry_sel)
      2'h0: cfg_cycles = 32'(CFG_T0_US * CLK_MHZ);
      2'h1: cfg_cycles = 32'(CFG_T1_US * CLK_MHZ);
      2'h2: cfg_cycles = 32'(CFG_T2_US * CLK_MHZ);
      2'h3: cfg_cycles = 32'(CFG_T3_US * CLK_MHZ);
    endcase
    unique case (cpl_to_sel)
      2'h0: cpl_cycles = 32'(CPL_T0_US * CLK_MHZ);
      2'h1: cpl_cycles = 32'(CPL_T1_US * CLK_MHZ);
      2'h2: cpl_cycles = 32'(CPL_T2_US * CLK_MHZ);
      2'h3: cpl_cycles = 32'(CPL_T3_US * CLK_MHZ);
    endcase
  end

  // Which bridge control bit counts depends on the bridge direction
  logic long_discard;
  assign long_discard = reverse_mode ? bridge_ctrl[BRCTL_REV_TIME_BIT]
                                     : bridge_ctrl[BRCTL_FWD_TIME_BIT];

  // Loopback needs the whole strap pattern, not the mode strap alone
  logic strap_pattern;
  assign strap_pattern = !strap[0] && strap[1] && strap[2] && strap[3] && strap[4];

  // Every output registered to keep timing clean toward the bridge core
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fc_update_each_credit <= 1'b0;
      discard_timer_enable  <= 1'b1;
      discard_clocks        <= 16'(STD_DISCARD);
      cfg_retry_cycles      <= 32'(CFG_T1_US * CLK_MHZ);
      cpl_timeout_cycles    <= 32'(CPL_T1_US * CLK_MHZ);
      dt_in_order           <= 1'b0;
      upstream_tc           <= TC_ZERO;
      loopback_active       <= 1'b0;
      primary_lockout       <= 1'b0;
    end else begin
      fc_update_each_credit <= fc_pace;
      discard_timer_enable  <= !discard_dis && !bridge_ctrl[BRCTL_DISCARD_BIT];
      discard_clocks        <= discard_short ? 16'(SHORT_DISCARD)
                             : (long_discard ? 16'(LONG_DISCARD) : 16'(STD_DISCARD));
      cfg_retry_cycles      <= cfg_cycles;
      cpl_timeout_cycles    <= cpl_cycles;
      dt_in_order           <= dt_order;
      upstream_tc           <= iso_en ? iso_tc : TC_ZERO;
      loopback_active       <= loopback && strap_pattern;
      primary_lockout       <= lockout;
    end
  end

endmodule
`default_nettype wire

// [rtl/tuning_pkg.sv]
package tuning_pkg;

  // ----------------------------------------------------------------
  // Register location and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] TUNING_OFFSET      = 8'h40;
  localparam int         FC_PACE_BIT        = 15;
  localparam int         RETRY_FLAG_BIT     = 16;
  localparam int         RETRY_LIM_LO       = 17;
  localparam int         DISCARD_DIS_BIT    = 19;
  localparam int         DISCARD_SHORT_BIT  = 20;
  localparam int         CFG_RETRY_LO       = 21;
  localparam int         DT_ORDER_BIT       = 23;
  localparam int         CPL_TO_LO          = 24;
  localparam int         ISO_EN_BIT         = 26;
  localparam int         ISO_TC_LO          = 27;
  localparam int         LOOPBACK_BIT       = 30;
  localparam int         LOCKOUT_BIT        = 31;
  localparam int         BRCTL_FWD_TIME_BIT = 24;
  localparam int         BRCTL_REV_TIME_BIT = 25;
  localparam int         BRCTL_DISCARD_BIT  = 27;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RETRY_LIM_RST = 2'h0;
  localparam logic [1:0] CFG_RETRY_RST = 2'h1;
  localparam logic [1:0] CPL_TO_RST    = 2'h1;
  localparam logic [2:0] ISO_TC_RST    = 3'h1;
  localparam logic [2:0] TC_ZERO       = 3'h0;

  // ----------------------------------------------------------------
  // Timing: figures and cycle counts at 100 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int CFG_T0_US     = 25;
  localparam int CFG_T1_US     = 500;
  localparam int CFG_T2_US     = 5000;
  localparam int CFG_T3_US     = 25000;
  localparam int CPL_T0_US     = 50;
  localparam int CPL_T1_US     = 1000;
  localparam int CPL_T2_US     = 10000;
  localparam int CPL_T3_US     = 50000;
  localparam int SHORT_DISCARD = 64;
  localparam int LONG_DISCARD  = 32768;
  localparam int STD_DISCARD   = 1024;
  localparam logic [31:0] RETRY_LIM1 = 32'h0000_0100;
  localparam logic [31:0] RETRY_LIM2 = 32'h0001_0000;
  localparam logic [31:0] RETRY_LIM3 = 32'h8000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_primary;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic        valid;
    logic        lockout_refused;
    logic [31:0] rdata;
  } cfg_rsp_s;

endpackage

// [rtl/sync_two_ff.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic stage_one;

  // Only the second stage is read downstream
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage_one <= 1'b0;
      dout      <= 1'b0;
    end else begin
      stage_one <= din;
      dout      <= stage_one;
    end
  end
endmodule
`default_nettype wire

// [tb/bridge_tuning_control_props.sv]
`timescale 1ns/1ps
`default_nettype none
module bridge_tuning_control_props (
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire tuning_pkg::cfg_req_s cfg_req,
  input wire tuning_pkg::cfg_rsp_s cfg_rsp,
  input wire logic                 txn_start,
  input wire logic                 retry_expired,
  input wire logic                 fc_update_each_credit,
  input wire logic                 discard_timer_enable,
  input wire logic [15:0]          discard_clocks,
  input wire logic [31:0]          cfg_retry_cycles,
  input wire logic [31:0]          cpl_timeout_cycles,
  input wire logic                 dt_in_order,
  input wire logic [2:0]           upstream_tc,
  input wire logic                 primary_lockout
);
  import tuning_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  function automatic logic [31:0] cfg_cyc(input logic [1:0] s);
    return 32'((s == 2'h0 ? CFG_T0_US : s == 2'h1 ? CFG_T1_US :
                s == 2'h2 ? CFG_T2_US : CFG_T3_US) * CLK_MHZ);
  endfunction

  function automatic logic [31:0] cpl_cyc(input logic [1:0] s);
    return 32'((s == 2'h0 ? CPL_T0_US : s == 2'h1 ? CPL_T1_US :
                s == 2'h2 ? CPL_T2_US : CPL_T3_US) * CLK_MHZ);
  endfunction

  // Secondary read answered; outputs must follow the read fields a cycle later
  sequence s_rd;
    cfg_req.valid && !cfg_req.write && !cfg_req.from_primary &&
      cfg_req.addr == TUNING_OFFSET ##1 cfg_rsp.valid;
  endsequence

  sequence s_pri_req;
    cfg_req.valid && cfg_req.from_primary && cfg_req.addr == TUNING_OFFSET;
  endsequence

  a_rsp_next: assert property (cfg_req.valid && cfg_req.addr == TUNING_OFFSET |=>
    cfg_rsp.valid)
    else $error("no response after register access");
  // The lockout output shows, one cycle late, the level the request met
  a_refuse_pri: assert property (s_pri_req |=>
    cfg_rsp.lockout_refused == primary_lockout && (!primary_lockout || cfg_rsp.rdata == 32'h0))
    else $error("primary access not handled per lockout");
  a_sec_served: assert property (cfg_req.valid && !cfg_req.from_primary |=>
    !cfg_rsp.lockout_refused)
    else $error("secondary access refused");
  a_pace_out: assert property (s_rd |=>
    fc_update_each_credit == $past(cfg_rsp.rdata[15]))
    else $error("credit pacing output wrong");
  a_order_out: assert property (s_rd |=>
    dt_in_order == $past(cfg_rsp.rdata[23]))
    else $error("ordering output wrong");
  a_iso_map: assert property (s_rd |=>
    upstream_tc == ($past(cfg_rsp.rdata[26]) ? $past(cfg_rsp.rdata[29:27]) : 3'h0))
    else $error("traffic class output wrong");
  a_short_disc: assert property (s_rd |=>
    !$past(cfg_rsp.rdata[20]) || discard_clocks == 16'(SHORT_DISCARD))
    else $error("short discard time wrong");
  a_cfg_tmo: assert property (s_rd |=>
    cfg_retry_cycles == cfg_cyc($past(cfg_rsp.rdata[22:21])))
    else $error("config retry timeout wrong");
  a_cpl_tmo: assert property (s_rd |=>
    cpl_timeout_cycles == cpl_cyc($past(cfg_rsp.rdata[25:24])))
    else $error("completion timeout wrong");
  a_lock_level: assert property (s_rd |=>
    primary_lockout == $past(cfg_rsp.rdata[31]))
    else $error("lockout output wrong");
  a_start_wins: assert property (txn_start |=> !retry_expired)
    else $error("expiry right after new transaction");
endmodule

bind bridge_tuning_control_upper bridge_tuning_control_props i_bridge_tuning_control_props (
  .sys_clk, .nrst, .cfg_req, .cfg_rsp, .txn_start, .retry_expired, .fc_update_each_credit,
  .discard_timer_enable, .discard_clocks, .cfg_retry_cycles, .cpl_timeout_cycles,
  .dt_in_order, .upstream_tc, .primary_lockout
);
`default_nettype wire

// [tb/tb_bridge_tuning_control_upper.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_tuning_control_upper;
  import tuning_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        nrst        = 1'b0;
  cfg_req_s    req         = '0;
  cfg_rsp_s    rsp, got;
  logic [31:0] bridge_ctrl = 32'h0;
  logic [4:0]  st          = 5'h10;
  logic        retry_seen  = 1'b0;
  logic        txn_start   = 1'b0;
  logic        rexp, fc, den, dto, lpb, plk;
  logic [15:0] dclk;
  logic [31:0] crc, cpc;
  logic [2:0]  tc;
  int          failures    = 0;
  int          n_checks    = 0;
  int          n_exp       = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rexp === 1'b1) n_exp++;

  bridge_tuning_control_upper i_bridge_tuning_control_upper (
    .sys_clk(sys_clk), .nrst(nrst), .cfg_req(req), .cfg_rsp(rsp), .bridge_ctrl(bridge_ctrl),
    .test_strap_zero(st[4]), .test_strap_one(st[3]), .test_strap_two(st[2]),
    .mask_input_strap(st[1]), .direction_select_strap(st[0]), .retry_seen(retry_seen),
    .txn_start(txn_start), .retry_expired(rexp), .fc_update_each_credit(fc),
    .discard_timer_enable(den), .discard_clocks(dclk), .cfg_retry_cycles(crc),
    .cpl_timeout_cycles(cpc), .dt_in_order(dto), .upstream_tc(tc), .loopback_active(lpb),
    .primary_lockout(plk)
  );

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Returns with the answer in got and the control outputs settled
  task automatic acc(input logic wr, input logic pri, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, write: wr, from_primary: pri, addr: a, be: be, wdata: wd};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
    got = rsp;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd;
    acc(1'b0, 1'b0, TUNING_OFFSET, 4'hF, 32'h0);
  endtask

  task automatic retries(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      retry_seen <= 1'b1;
    end
    @(posedge sys_clk);
    retry_seen <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd;
    chk(got.rdata[31:15] === 17'h11240, "reset value");
    chk(den === 1'b1 && dclk === 16'(STD_DISCARD), "reset discard");
    chk(tc === TC_ZERO && fc === 1'b0, "reset outs");
    chk(dto === 1'b0 && lpb === 1'b0 && plk === 1'b1, "reset levels");
    chk(crc === 32'(CFG_T1_US * CLK_MHZ), "reset cfg tmo");
    chk(cpc === 32'(CPL_T1_US * CLK_MHZ), "reset cpl tmo");
  endtask

  task automatic t_lock;
    acc(1'b1, 1'b1, TUNING_OFFSET, 4'hF, 32'h0);
    chk(got.lockout_refused === 1'b1 && got.rdata === 32'h0, "not refused");
    rd;
    chk(got.rdata[31] === 1'b1 && plk === 1'b1, "lock lost");
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h8, 32'h0900_0000);
    acc(1'b0, 1'b1, TUNING_OFFSET, 4'hF, 32'h0);
    chk(plk === 1'b0 && got.rdata[31:16] === 16'h0920, "unlock");
    acc(1'b0, 1'b0, 8'h44, 4'hF, 32'h0);
    chk(got.valid === 1'b0, "unmapped answered");
  endtask

  task automatic t_fields;
    logic [31:0] wd;
    int          ct[4] = '{CFG_T0_US, CFG_T1_US, CFG_T2_US, CFG_T3_US};
    int          pt[4] = '{CPL_T0_US, CPL_T1_US, CPL_T2_US, CPL_T3_US};
    for (int k = 0; k < 4; k++) begin
      wd = 32'h0;
      wd[15] = ~k[0];
      wd[18:17] = 2'(k);
      wd[22:21] = 2'(k);
      wd[23] = k[1];
      wd[25:24] = 2'(k);
      wd[26] = k[1];
      wd[29:27] = 3'(k + 2);
      acc(1'b1, 1'b0, TUNING_OFFSET, 4'hF, wd);
      chk(crc === 32'(ct[k] * CLK_MHZ), "cfg timeout");
      chk(cpc === 32'(pt[k] * CLK_MHZ), "cpl timeout");
      chk(fc === wd[15] && dto === wd[23], "pacing or order");
      chk(tc === (wd[26] ? wd[29:27] : TC_ZERO), "class");
      rd;
      chk(got.rdata[29:15] === wd[29:15], "readback");
    end
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h1, 32'hFFFF_FFFF);
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h2, 32'hFFFF_FFFF);
    rd;
    chk(got.rdata[31:15] === {wd[31:16], 1'b1} && fc === 1'b1, "byte enables");
  endtask

  task automatic dcase(input logic [31:0] bc, input logic [31:0] wd,
                       input logic [15:0] ec, input logic en);
    @(posedge sys_clk);
    bridge_ctrl <= bc;
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h4, wd);
    chk((en == 1'b0 || dclk === ec) && den === en, "discard");
  endtask

  task automatic t_retry;
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h4, 32'h0002_0000);
    n_exp = 0;
    retries(255);
    // A retry in the same cycle as a new transaction must not count
    @(posedge sys_clk);
    retry_seen <= 1'b1;
    txn_start  <= 1'b1;
    @(posedge sys_clk);
    retry_seen <= 1'b0;
    txn_start  <= 1'b0;
    retries(255);
    repeat (2) @(posedge sys_clk);
    chk(n_exp == 0, "early expiry");
    retries(1);
    repeat (2) @(posedge sys_clk);
    chk(n_exp == 1, "no expiry at limit");
    rd;
    chk(got.rdata[16] === 1'b1, "flag not set");
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h4, 32'h0003_0000);
    rd;
    chk(got.rdata[16] === 1'b0, "flag not cleared");
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h4, 32'h0000_0000);
    n_exp = 0;
    retries(300);
    repeat (2) @(posedge sys_clk);
    chk(n_exp == 0, "expiry with no limit");
  endtask

  task automatic t_loop;
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h8, 32'h4800_0000);
    rd;
    chk(got.rdata[30] === 1'b0 && lpb === 1'b0, "forward loopback");
    @(posedge sys_clk);
    st <= 5'h0F;
    repeat (4) @(posedge sys_clk);
    acc(1'b1, 1'b0, TUNING_OFFSET, 4'h8, 32'h4800_0000);
    rd;
    chk(got.rdata[30] === 1'b1 && lpb === 1'b1, "reverse loopback");
    dcase(32'h0200_0000, 32'h0, 16'h8000, 1'b1);
    @(posedge sys_clk);
    st <= 5'h07;
    repeat (5) @(posedge sys_clk);
    chk(lpb === 1'b0, "strap gate");
  endtask

  task automatic t_rerun;
    @(posedge sys_clk);
    st   <= 5'h00;
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd;
    chk(got.rdata[31:15] === 17'h01240, "strap low reset");
    chk(plk === 1'b0 && lpb === 1'b0 && rexp === 1'b0, "strap low outs");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset;
    t_lock;
    t_fields;
    dcase(32'h0100_0000, 32'h0010_0000, 16'h0040, 1'b1);
    dcase(32'h0100_0000, 32'h0, 16'h8000, 1'b1);
    dcase(32'h0200_0000, 32'h0, 16'h0400, 1'b1);
    dcase(32'h0800_0000, 32'h0008_0000, 16'h0, 1'b0);
    dcase(32'h0000_0000, 32'h0008_0000, 16'h0, 1'b0);
    dcase(32'h0800_0000, 32'h0000_0000, 16'h0, 1'b0);
    t_retry;
    t_loop;
    t_rerun;
    wrap_up;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
